/* isa_cfg.svh */
// Constants for the input and supply alarm register block.
// Assumes inclusion by the modules and testbench files of this block only.
`ifndef ISA_CFG_SVH
`define ISA_CFG_SVH

// ==========================================
// Register byte addresses
`define ISA_ADDR_STATUS 8'h20
`define ISA_ADDR_HIGH_TH 8'h24
`define ISA_ADDR_LOW_TH 8'h28
`define ISA_ADDR_BITS 8

// ==========================================
// Status word bit positions
`define ISA_BIT_SUP_LOW_ACT 15
`define ISA_BIT_SUP_HIGH_ACT 14
`define ISA_BIT_IN_LOW_ACT 11
`define ISA_BIT_IN_HIGH_ACT 10
`define ISA_BIT_SUP_LOW_LAT 7
`define ISA_BIT_SUP_HIGH_LAT 6
`define ISA_BIT_IN_LOW_LAT 5
`define ISA_BIT_IN_HIGH_LAT 4
`define ISA_BIT_SUMMARY 0

// ==========================================
// Threshold word fields and reset values
`define ISA_HYST_MSB 31
`define ISA_HYST_LSB 24
`define ISA_TH_MSB 15
`define ISA_HYST_STEP_MSB 7
`define ISA_HYST_STEP_LSB 2
`define ISA_HYST_RST 8'h00
`define ISA_HIGH_TH_RST 16'hffff
`define ISA_LOW_TH_RST 16'h0000

// ==========================================
// Bus encodings
`define ISA_HTRANS_NONSEQ 2'b10
`define ISA_HTRANS_SEQ 2'b11
`define ISA_HRESP_OKAY 1'b0

`endif

/* isa_pkg.sv */
// Types shared by the alarm register block.
// Assumes isa_cfg.svh is on the include path.
package isa_pkg;
   // Hysteresis comparator state for the input alarm
   typedef enum logic [1:0] {
      isa_in_clear,
      isa_in_high,
      isa_in_low
   } isa_state_type;
endpackage : isa_pkg

/* isa_ahb_slave.sv */
// AHB-Lite slave front end: captures the address phase of a transfer.
// Assumes one master, single word transfers, zero wait states.
`timescale 1ns/100ps
`include "isa_cfg.svh"
module isa_ahb_slave
   import isa_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Address phase from the master
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   // Captured write request and address for the data phase, live read strobe
   output logic wr_q,
   output logic rd_pulse,
   output logic [7:0] addr_q
);
   // ==========================================
   // Address phase decode
   wire logic xfer_valid;
   assign xfer_valid = hsel && hready && htrans[1];
   // Read strobe is raised during the address phase so the read mux can load
   assign rd_pulse = xfer_valid && !hwrite;

   // Data phase write request held one cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         addr_q <= 8'h00;
      end else begin
         wr_q <= xfer_valid && hwrite;
         if (xfer_valid) begin
            addr_q <= haddr[7:0];
         end
      end
   end
endmodule : isa_ahb_slave

/* isa_window.sv */
// Window comparator with hysteresis for the input alarm.
// Assumes a one-cycle sample strobe with a stable result.
`timescale 1ns/100ps
`include "isa_cfg.svh"
module isa_window
   import isa_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Sample and limits
   input wire logic sample_valid,
   input wire logic [15:0] sample,
   input wire logic [15:0] upper,
   input wire logic [15:0] lower,
   input wire logic [5:0] hyst,
   // Active flags
   output logic high_active_q,
   output logic low_active_q
);
   // ==========================================
   // Comparison with hysteresis
   isa_state_type state_q, state_d;
   wire logic [16:0] up_release;
   wire logic [16:0] lo_release;
   wire logic over_up;
   wire logic under_lo;
   wire logic below_up_rel;
   wire logic above_lo_rel;
   // Release points widened so hysteresis cannot wrap the comparison
   assign up_release = {1'b0, upper} - {11'h000, hyst};
   assign lo_release = {1'b0, lower} + {11'h000, hyst};
   assign over_up = sample > upper;
   assign under_lo = sample < lower;
   assign below_up_rel = up_release[16] ? 1'b0 : ({1'b0, sample} < up_release);
   assign above_lo_rel = {1'b0, sample} > lo_release;

   // Next state: a flag clears only once past its release point
   always_comb begin
      state_d = state_q;
      if (sample_valid) begin
         unique case (state_q)
            isa_in_clear: begin
               if (over_up) state_d = isa_in_high;
               else if (under_lo) state_d = isa_in_low;
            end
            isa_in_high: begin
               if (under_lo) state_d = isa_in_low;
               else if (below_up_rel) state_d = isa_in_clear;
            end
            isa_in_low: begin
               if (over_up) state_d = isa_in_high;
               else if (above_lo_rel) state_d = isa_in_clear;
            end
            default: state_d = isa_in_clear;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) state_q <= isa_in_clear;
      else state_q <= state_d;
   end

   assign high_active_q = (state_q == isa_in_high);
   assign low_active_q = (state_q == isa_in_low);
endmodule : isa_window

/* isa_alarm_regs.sv */
// Alarm status and threshold registers behind an AHB-Lite slave.
// Assumes conversion results arrive with a one-cycle valid strobe and
// supply comparator levels are synchronous to hclk.
//
// Notes on behaviour
// - Reserved bits always read zero.
// - Bits 15/14 show active supply low/high.
// - Bits 11/10 show active input low/high.
// - Bits 7/6 hold latched supply low/high.
// - Bits 5/4 hold latched input low/high.
// - Flags one on alarm, read-only, reset zero.
// - Bit 0 ORs the four latched flags.
// - High threshold word at 24h, little endian.
// - Bits 31:24 hysteresis, read/write, reset zero.
// - Bits 15:0 upper limit, reset all ones.
// - Low threshold at 28h, reset zero.
// - Status word at 20h, little endian.
`timescale 1ns/100ps
`include "isa_cfg.svh"
module isa_alarm_regs
   import isa_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Converter results and supply comparators
   input wire logic sample_valid,
   input wire logic [15:0] sample,
   input wire logic supply_low_cond,
   input wire logic supply_high_cond,
   // Summary alarm out
   output logic any_alarm_summary
);
   // ==========================================
   // Bus front end
   logic wr_q;
   logic rd_pulse;
   logic [7:0] addr_q;
   isa_ahb_slave u_slave (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hready(hready),
      .wr_q(wr_q),
      .rd_pulse(rd_pulse),
      .addr_q(addr_q)
   );
   // Zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = `ISA_HRESP_OKAY;

   // ==========================================
   // Address decode
   // Only the low address byte is decoded, so the three words repeat every
   // 256 bytes; software must not rely on upper address bits to separate them.
   function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] reg_addr);
      addr_hit = (addr == reg_addr);
   endfunction : addr_hit

   // Read decodes use the live address phase, write decodes the captured one
   wire logic rd_high = rd_pulse && addr_hit(haddr[7:0], `ISA_ADDR_HIGH_TH);
   wire logic rd_low = rd_pulse && addr_hit(haddr[7:0], `ISA_ADDR_LOW_TH);

   // ==========================================
   // Registers and their write decode
   logic [7:0] input_hysteresis_q; // Full byte kept, low bits as written
   logic [15:0] input_upper_limit_q; // Upper input limit
   logic [15:0] input_lower_limit_q; // Lower input limit
   wire logic wr_high = wr_q && addr_hit(addr_q, `ISA_ADDR_HIGH_TH);
   wire logic wr_low = wr_q && addr_hit(addr_q, `ISA_ADDR_LOW_TH);

   // Threshold registers; sub-word writes are treated as whole words
   // Limitation: hsize is ignored, so a byte write rewrites the whole word
   // with whatever stands on the other byte lanes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         input_hysteresis_q <= `ISA_HYST_RST;
         input_upper_limit_q <= `ISA_HIGH_TH_RST;
         input_lower_limit_q <= `ISA_LOW_TH_RST;
      end else begin
         if (wr_high) begin
            input_hysteresis_q <= hwdata[`ISA_HYST_MSB:`ISA_HYST_LSB];
            input_upper_limit_q <= hwdata[`ISA_TH_MSB:0];
         end
         if (wr_low) input_lower_limit_q <= hwdata[`ISA_TH_MSB:0];
      end
   end

   // ==========================================
   // Active input flags
   logic input_high_active;
   logic input_low_active;
   // Hysteresis step is the upper six bits; host keeps low bits zero
   // Bits 25:24 are kept for read-back only and never reach the comparator
   isa_window u_window (
      .hclk(hclk),
      .hresetn(hresetn),
      .sample_valid(sample_valid),
      .sample(sample),
      .upper(input_upper_limit_q),
      .lower(input_lower_limit_q),
      .hyst(input_hysteresis_q[`ISA_HYST_STEP_MSB:`ISA_HYST_STEP_LSB]),
      .high_active_q(input_high_active),
      .low_active_q(input_low_active)
   );

   // ==========================================
   // Active supply flags registered from the comparator levels
   // One stage only: the levels are taken as synchronous to hclk; an
   // asynchronous source would need a synchroniser in front of this block
   logic supply_low_active_q;
   logic supply_high_active_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         supply_low_active_q <= 1'b0;
         supply_high_active_q <= 1'b0;
      end else begin
         supply_low_active_q <= supply_low_cond;
         supply_high_active_q <= supply_high_cond;
      end
   end

   // ==========================================
   // Latched flags: a set in the read cycle wins over the clear
   logic [3:0] latched_q, latched_d; // {sup_lo, sup_hi, in_lo, in_hi}
   wire logic [3:0] active_vec = {supply_low_active_q, supply_high_active_q,
                                  input_low_active, input_high_active};
   // The clear acts on the address phase, so a read that the master gives up
   // before its data phase still empties the flags
   wire logic rd_status = rd_pulse && addr_hit(haddr[7:0], `ISA_ADDR_STATUS);
   assign latched_d = (rd_status ? 4'h0 : latched_q) | active_vec;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) latched_q <= 4'h0;
      else latched_q <= latched_d;
   end
   assign any_alarm_summary = |latched_q;

   // ==========================================
   // Read data assembly; all other bits zero
   // Status word layout, low byte at 20h:
   //   15 supply low active, 14 supply high active, 13:12 zero
   //   11 input low active, 10 input high active, 9:8 zero
   //   7:4 latched copies in the same order, 3:1 zero, 0 summary
   // Active bits follow the live comparators; latched bits need a read to clear
   logic [31:0] status_word;
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`ISA_BIT_SUP_LOW_ACT] = supply_low_active_q;
      status_word[`ISA_BIT_SUP_HIGH_ACT] = supply_high_active_q;
      status_word[`ISA_BIT_IN_LOW_ACT] = input_low_active;
      status_word[`ISA_BIT_IN_HIGH_ACT] = input_high_active;
      status_word[`ISA_BIT_SUP_LOW_LAT] = latched_q[3];
      status_word[`ISA_BIT_SUP_HIGH_LAT] = latched_q[2];
      status_word[`ISA_BIT_IN_LOW_LAT] = latched_q[1];
      status_word[`ISA_BIT_IN_HIGH_LAT] = latched_q[0];
      status_word[`ISA_BIT_SUMMARY] = |latched_q;
   end
   wire logic [31:0] high_word = {input_hysteresis_q, 8'h00, input_upper_limit_q};
   wire logic [31:0] low_word = {16'h0000, input_lower_limit_q};
   // Snapshot taken in the address phase so the read and clear agree
   // Read data is registered and stands until the next read is taken, so a
   // master that stretches its data phase still sees the same word
   logic [31:0] rdata_d;
   always_comb begin
      unique case (haddr[7:0])
         `ISA_ADDR_STATUS: rdata_d = status_word;
         `ISA_ADDR_HIGH_TH: rdata_d = high_word;
         `ISA_ADDR_LOW_TH: rdata_d = low_word;
         default: rdata_d = 32'h0000_0000; // Unmapped reads zero
      endcase
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) hrdata <= 32'h0000_0000;
      else if (rd_pulse) hrdata <= rdata_d;
   end

   // ==========================================
   // Assertions
   // Summary pin must be the OR of the latched flags at all times
   a_summary_or: assert property (@(posedge hclk) disable iff (!hresetn)
      any_alarm_summary == (|latched_q)) else $error("summary mismatch");
   // A latched flag may only drop at a status read
   a_latch_holds: assert property (@(posedge hclk) disable iff (!hresetn)
      (latched_q[0] && !rd_status) |=> latched_q[0]) else $error("latch lost");
   // An active condition is copied into its latched flag the next cycle
   a_latch_sets: assert property (@(posedge hclk) disable iff (!hresetn)
      input_high_active |=> latched_q[0]) else $error("latch not set");
   a_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      (status_word[31:16] == 16'h0) && (high_word[23:16] == 8'h0))
      else $error("reserved bits set");
   a_high_write: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_high |=> input_upper_limit_q == $past(hwdata[15:0]))
      else $error("upper limit write");
   a_low_write: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_low |=> input_lower_limit_q == $past(hwdata[15:0]))
      else $error("lower limit write");
   a_supply_active: assert property (@(posedge hclk) disable iff (!hresetn)
      supply_low_cond |=> status_word[15] ##1 latched_q[3])
      else $error("supply flag");
   a_read_status: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_status |=> hrdata[0] == $past(|latched_q))
      else $error("status read");
   a_no_both: assert property (@(posedge hclk) disable iff (!hresetn)
      !(input_high_active && input_low_active)) else $error("both input flags");
   // Hysteresis byte is stored whole, as the host sends it
   a_hyst_write: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_high |=> input_hysteresis_q == $past(hwdata[`ISA_HYST_MSB:`ISA_HYST_LSB]))
      else $error("hysteresis write");
   // Reserved bytes of the threshold words read back as zero
   a_high_rd_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_high |=> hrdata[23:16] == 8'h00) else $error("high word reserved bits");
   a_low_rd_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_low |=> hrdata[31:16] == 16'h0000) else $error("low word reserved bits");
   // Every reserved field of the status word reads zero
   a_status_rd_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_status |=> (hrdata[31:16] == 16'h0000) && (hrdata[13:12] == 2'b00)
         && (hrdata[9:8] == 2'b00) && (hrdata[3:1] == 3'b000))
      else $error("status reserved bits");
   // Threshold reads return the stored fields at their positions
   a_high_rd_data: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_high |=> hrdata[15:0] == $past(input_upper_limit_q))
      else $error("upper limit read");
   a_high_rd_hyst: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_high |=> hrdata[31:24] == $past(input_hysteresis_q))
      else $error("hysteresis read");
   a_low_rd_data: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_low |=> hrdata[15:0] == $past(input_lower_limit_q))
      else $error("lower limit read");
   // A status read returns the flags as they stood in its address phase
   a_rd_supply: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_status |=> hrdata[15:14] == $past({supply_low_active_q, supply_high_active_q}))
      else $error("supply active read");
   a_rd_input: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_status |=> hrdata[11:10] == $past({input_low_active, input_high_active}))
      else $error("input active read");
   a_rd_latched: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_status |=> hrdata[7:4] == $past(latched_q))
      else $error("latched flags read");
   // A read with no condition present empties the latched flags
   a_read_clears: assert property (@(posedge hclk) disable iff (!hresetn)
      (rd_status && (active_vec == 4'h0)) |=> latched_q == 4'h0)
      else $error("read did not clear");
   // No latched flag is lost between reads
   a_latch_all_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      !rd_status |=> (latched_q & $past(latched_q)) == $past(latched_q))
      else $error("latched flag dropped");
   // Flags are read-only: nothing but a condition can raise one
   a_no_false_set: assert property (@(posedge hclk) disable iff (!hresetn)
      (active_vec == 4'h0) |=> (latched_q & ~$past(latched_q)) == 4'h0)
      else $error("flag set without condition");
   // High supply path mirrors the low one
   a_sup_high_trip: assert property (@(posedge hclk) disable iff (!hresetn)
      supply_high_cond |=> status_word[`ISA_BIT_SUP_HIGH_ACT] ##1 latched_q[2])
      else $error("supply high flag");
   a_in_low_latch: assert property (@(posedge hclk) disable iff (!hresetn)
      input_low_active |=> latched_q[1]) else $error("low latch not set");
   // Summary pin rises the cycle after any condition
   a_sum_rises: assert property (@(posedge hclk) disable iff (!hresetn)
      (|active_vec) |=> any_alarm_summary) else $error("summary not raised");
   // Active supply flags follow the comparators one cycle late
   a_supply_track: assert property (@(posedge hclk) disable iff (!hresetn)
      $past(hresetn) |-> ({supply_low_active_q, supply_high_active_q} ==
         $past({supply_low_cond, supply_high_cond}))) else $error("supply tracking");
   // Input flags move only on a new conversion result
   a_flags_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      !sample_valid |=> $stable({input_high_active, input_low_active}))
      else $error("input flag moved");
   // A result beyond a limit raises its flag the next cycle
   a_window_high: assert property (@(posedge hclk) disable iff (!hresetn)
      (sample_valid && (sample > input_upper_limit_q) && (sample >= input_lower_limit_q))
      |=> input_high_active) else $error("high limit missed");
   a_window_low: assert property (@(posedge hclk) disable iff (!hresetn)
      (sample_valid && (sample < input_lower_limit_q) && (sample <= input_upper_limit_q))
      |=> input_low_active) else $error("low limit missed");

   // ==========================================
   // Coverage of the main scenarios
   c_high_trip: cover property (@(posedge hclk) input_high_active ##1 rd_status);
   c_low_trip: cover property (@(posedge hclk) input_low_active);
   c_clear_read: cover property (@(posedge hclk) latched_q != 0 ##1 rd_status ##1 latched_q == 0);
   c_supply_trip: cover property (@(posedge hclk) supply_low_active_q ##1 rd_status);
   // Hysteresis keeps the flag up through a result just inside the limit
   c_hyst_hold: cover property (@(posedge hclk)
      (input_high_active && sample_valid) ##1 input_high_active);
endmodule : isa_alarm_regs

/* isa_host_model.sv */
// Host controller model: an AHB-Lite master that issues single word transfers.
// Assumes one slave whose hreadyout is fed back as hready.
`timescale 1ns/100ps
`include "isa_cfg.svh"
module isa_host_model (
   // Clock
   input wire logic hclk,
   // Master outputs
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   // Slave answer
   input wire logic [31:0] hrdata,
   input wire logic hready
);
   // ==========================================
   // Idle bus at time zero
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end

   // ==========================================
   // One transfer: address phase, then data phase, each held until hready
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= `ISA_HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      // Low hysteresis bits are always written as zero
      hwdata <= (a[7:0] == `ISA_ADDR_HIGH_TH) ? {d[31:26], 2'b00, d[23:0]} : d;
      do @(posedge hclk); while (hready !== 1'b1);
      // Read data is taken at the edge that ends the data phase
      r = hrdata;
   endtask : xfer
endmodule : isa_host_model

/* tb_top.sv */
// Self-checking bench for the alarm register block.
// Assumes the host model drives the bus and hready loops back from hreadyout.
`timescale 1ns/100ps
`include "isa_cfg.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
   $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_top;
   // ==========================================
   // Clock, reset and wires
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   wire hsel, hwrite;
   wire [31:0] haddr, hwdata;
   wire [1:0] htrans;
   wire [2:0] hsize;
   logic [31:0] hrdata;
   logic hreadyout, hresp, any_alarm_summary;
   logic sample_valid = 1'b0;
   logic [15:0] sample = 16'h0;
   logic supply_low_cond = 1'b0;
   logic supply_high_cond = 1'b0;
   int compares = 0;
   int mismatches = 0;

   // 50 MHz clock
   always #10 hclk = ~hclk;

   isa_alarm_regs u_isa_alarm_regs (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .sample_valid(sample_valid), .sample(sample), .supply_low_cond(supply_low_cond),
      .supply_high_cond(supply_high_cond), .any_alarm_summary(any_alarm_summary));

   isa_host_model u_isa_host_model (.hclk(hclk), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hrdata(hrdata), .hready(hreadyout));

   // ==========================================
   // Shared helpers
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      u_isa_host_model.xfer(1'b1, a, d, r);
   endtask : wr

   task automatic rd(input logic [31:0] a, input logic [31:0] e, input string n);
      logic [31:0] r;
      u_isa_host_model.xfer(1'b0, a, 32'h0, r);
      `CHK(n, e, r)
      `CHK("hresp", `ISA_HRESP_OKAY, hresp)
   endtask : rd

   // Summary pin first, then the status word (the read consumes latched flags)
   task automatic st(input logic [31:0] e);
      `CHK("summary pin", e[0], any_alarm_summary)
      rd(`ISA_ADDR_STATUS, e, "status");
   endtask : st

   // One conversion result, then time for the flags to settle
   task automatic smp(input logic [15:0] v);
      @(posedge hclk);
      sample <= v;
      sample_valid <= 1'b1;
      @(posedge hclk);
      sample_valid <= 1'b0;
      repeat (3) @(posedge hclk);
   endtask : smp

   // ==========================================
   // Scenarios
   task automatic t_reset();
      st(32'h0);
      rd(`ISA_ADDR_HIGH_TH, 32'h0000ffff, "high th rst");
      rd(`ISA_ADDR_LOW_TH, 32'h0, "low th rst");
      rd(32'h2c, 32'h0, "unmapped");
   endtask : t_reset

   task automatic t_regs();
      // Reserved bits read zero whatever is written
      wr(`ISA_ADDR_STATUS, 32'hffffffff);
      st(32'h0);
      wr(`ISA_ADDR_HIGH_TH, {6'd4, 2'b11, 8'hff, 16'd1000});
      rd(`ISA_ADDR_HIGH_TH, 32'h100003e8, "high th");
      wr(`ISA_ADDR_LOW_TH, 32'hffff0064);
      rd(`ISA_ADDR_LOW_TH, 32'h00000064, "low th");
   endtask : t_regs

   task automatic t_supply();
      for (int i = 0; i < 2; i++) begin
         @(posedge hclk);
         supply_low_cond <= (i == 0);
         supply_high_cond <= (i == 1);
         repeat (3) @(posedge hclk);
         st(i ? 32'h4041 : 32'h8081);
         @(posedge hclk);
         supply_low_cond <= 1'b0;
         supply_high_cond <= 1'b0;
         repeat (3) @(posedge hclk);
         // Condition gone: latched flag stays until the next read
         st(i ? 32'h0041 : 32'h0081);
         st(32'h0);
      end
   endtask : t_supply

   task automatic t_input();
      // Upper 1000, lower 100, hysteresis 4 from t_regs
      smp(16'd1001);
      st(32'h0411);
      smp(16'd996);
      st(32'h0411);
      smp(16'd995);
      st(32'h0011);
      st(32'h0);
      smp(16'd99);
      st(32'h0821);
      smp(16'd104);
      st(32'h0821);
      smp(16'd105);
      st(32'h0021);
      st(32'h0);
   endtask : t_input

   // ==========================================
   // Verdict and end of run
   task automatic end_sim();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim

   // Main sequence
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_regs();
      t_supply();
      t_input();
      end_sim();
   end

   // Watchdog: the whole run needs well under a thousand cycles
   initial begin
      #100000;
      mismatches++;
      end_sim();
   end
endmodule : tb_top
